// *** logic/uart_rx_pkg.sv ***
// constants, types and register layout for the receive buffer block
package uart_rx_pkg;

  // register byte addresses
  localparam logic [11:0] ADDR_DATA = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CTRL_B = 12'h008;
  localparam logic [11:0] ADDR_CTRL_C = 12'h00C;

  // status register bit positions
  localparam int STAT_RX_COMPLETE = 7;
  localparam int STAT_STOP_FAULT = 4;
  localparam int STAT_OVERRUN = 3;
  localparam int STAT_PARITY = 2;

  // control b bit positions
  localparam int CTLB_IRQ_EN = 7;
  localparam int CTLB_RX_EN = 4;
  localparam int CTLB_SIZE_2 = 2;
  localparam int CTLB_NINTH = 1;

  // control c bit positions
  localparam int CTLC_PAR_EN = 5;
  localparam int CTLC_PAR_ODD = 4;
  localparam int CTLC_TWO_STOP = 3;
  localparam int CTLC_SIZE_1 = 2;
  localparam int CTLC_SIZE_0 = 1;

  // reset values
  localparam logic [2:0] SIZE_RESET = 3'h3;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // character size codes
  localparam logic [2:0] SIZE_5 = 3'h0;
  localparam logic [2:0] SIZE_6 = 3'h1;
  localparam logic [2:0] SIZE_7 = 3'h2;
  localparam logic [2:0] SIZE_9 = 3'h7;

  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_PARITY = 2'b11,
    ST_STOP = 2'b10
  } rx_state_t;

  typedef struct packed {
    logic [8:0] data;
    logic stop_fault;
    logic overrun;
    logic parity_err;
  } rx_entry_t;

endpackage

// *** logic/uart_receive_buffer_status.sv ***
// receive buffer, error flags and parity checker of the serial port
`timescale 1ns/1ps

module uart_receive_buffer_status
  import uart_rx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic start_det_i,
  input wire logic bit_valid_i,
  input wire logic bit_value_i,
  input wire logic global_irq_en_i,
  output logic rx_irq_o,
  output logic rx_pin_owned_o
);

  // number of data bits for a size code; reserved codes act as eight
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    case (code)
      SIZE_5: data_bits = 4'h5;
      SIZE_6: data_bits = 4'h6;
      SIZE_7: data_bits = 4'h7;
      SIZE_9: data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

  // control state
  logic irq_en_r;
  logic irq_en_nxt;
  logic rx_en_r;
  logic rx_en_nxt;
  logic [2:0] size_r;
  logic [2:0] size_nxt;
  logic par_en_r;
  logic par_en_nxt;
  logic par_odd_r;
  logic par_odd_nxt;
  logic two_stop_r;
  logic two_stop_nxt;

  // frame assembly
  rx_state_t state_r;
  rx_state_t state_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [8:0] shift_r;
  logic [8:0] shift_nxt;
  logic par_bit_r;
  logic par_bit_nxt;
  rx_entry_t wait_r;
  rx_entry_t wait_nxt;
  logic wait_vld_r;
  logic wait_vld_nxt;
  logic lost_r;
  logic lost_nxt;

  // two entry buffer
  rx_entry_t buf_r [BUF_DEPTH];
  logic wr_ptr_r;
  logic wr_ptr_nxt;
  logic rd_ptr_r;
  logic rd_ptr_nxt;
  logic [1:0] count_r;
  logic [1:0] count_nxt;

  // bus answer
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic err_r;
  logic err_nxt;
  logic pop_ok_r;
  logic pop_ok_nxt;

  // bus decode
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire wr_acc = access & pwrite_i;
  wire rd_acc = access & ~pwrite_i;
  wire sel_data = (paddr_i == ADDR_DATA);
  wire sel_stat = (paddr_i == ADDR_STATUS);
  wire sel_ctlb = (paddr_i == ADDR_CTRL_B);
  wire sel_ctlc = (paddr_i == ADDR_CTRL_C);
  wire mapped = sel_data | sel_stat | sel_ctlb | sel_ctlc;

  // buffer state
  // flag from buffer fill
  wire rx_complete = (count_r != 2'h0);
  wire buf_full = (count_r == BUF_DEPTH);
  rx_entry_t head;
  assign head = buf_r[rd_ptr_r];
  wire [8:0] head_data = rx_complete ? head.data : 9'h000;
  wire head_fault = rx_complete & head.stop_fault;
  wire head_ovr = rx_complete & head.overrun;
  wire head_par = rx_complete & head.parity_err;

  wire overrun_evt = rx_en_r & (state_r == ST_IDLE) & start_det_i &
                     wait_vld_r & buf_full;
  wire move = rx_en_r & wait_vld_r & ~buf_full;
  // flush in the write cycle itself, so disable is never a cycle late
  wire flush = ~rx_en_r | ~rx_en_nxt;
  wire pop = rd_acc & sel_data & pop_ok_r & rx_complete;

  wire [3:0] nbits = data_bits(size_r);
  wire [3:0] last_bit = nbits - 4'h1;
  wire par_mismatch = (^shift_r) ^ par_bit_r ^ par_odd_r;

  // read words
  logic [7:0] stat_rd;
  logic [7:0] ctlb_rd;
  logic [7:0] ctlc_rd;
  logic [31:0] rd_word;

  always_comb
  begin
    stat_rd = 8'h00;
    stat_rd[STAT_RX_COMPLETE] = rx_complete;
    stat_rd[STAT_STOP_FAULT] = head_fault;
    stat_rd[STAT_OVERRUN] = head_ovr;
    stat_rd[STAT_PARITY] = head_par;
    ctlb_rd = 8'h00;
    ctlb_rd[CTLB_IRQ_EN] = irq_en_r;
    ctlb_rd[CTLB_RX_EN] = rx_en_r;
    ctlb_rd[CTLB_SIZE_2] = size_r[2];
    ctlb_rd[CTLB_NINTH] = head_data[8];
    ctlc_rd = 8'h00;
    ctlc_rd[CTLC_PAR_EN] = par_en_r;
    ctlc_rd[CTLC_PAR_ODD] = par_odd_r;
    ctlc_rd[CTLC_TWO_STOP] = two_stop_r;
    ctlc_rd[CTLC_SIZE_1] = size_r[1];
    ctlc_rd[CTLC_SIZE_0] = size_r[0];
    rd_word = 32'h0000_0000;
    if (sel_data)
      rd_word = {24'h00_0000, head_data[7:0]};
    else if (sel_stat)
      rd_word = {24'h00_0000, stat_rd};
    else if (sel_ctlb)
      rd_word = {24'h00_0000, ctlb_rd};
    else if (sel_ctlc)
      rd_word = {24'h00_0000, ctlc_rd};
  end

  // answer is sampled in setup so the access phase needs no wait state
  assign prdata_nxt = setup ? rd_word : prdata_r;
  assign err_nxt = setup ? ~mapped : err_r;
  // pop only if char seen at setup
  assign pop_ok_nxt = setup ? rx_complete : pop_ok_r;

  // control register writes
  always_comb
  begin
    irq_en_nxt = irq_en_r;
    rx_en_nxt = rx_en_r;
    size_nxt = size_r;
    par_en_nxt = par_en_r;
    par_odd_nxt = par_odd_r;
    two_stop_nxt = two_stop_r;
    if (wr_acc & sel_ctlb)
    begin
      irq_en_nxt = pwdata_i[CTLB_IRQ_EN];
      rx_en_nxt = pwdata_i[CTLB_RX_EN];
      size_nxt[2] = pwdata_i[CTLB_SIZE_2];
    end
    if (wr_acc & sel_ctlc)
    begin
      par_en_nxt = pwdata_i[CTLC_PAR_EN];
      par_odd_nxt = pwdata_i[CTLC_PAR_ODD];
      two_stop_nxt = pwdata_i[CTLC_TWO_STOP];
      size_nxt[1] = pwdata_i[CTLC_SIZE_1];
      size_nxt[0] = pwdata_i[CTLC_SIZE_0];
    end
  end

  // frame assembly and hand-off to the buffer
  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    par_bit_nxt = par_bit_r;
    wait_nxt = wait_r;
    wait_vld_nxt = wait_vld_r;
    lost_nxt = lost_r;
    if (move)
    begin
      wait_vld_nxt = 1'b0;
      lost_nxt = 1'b0;
    end
    if (overrun_evt)
    begin
      wait_vld_nxt = 1'b0;
      lost_nxt = 1'b1;
    end
    case (state_r)
      ST_IDLE:
        if (start_det_i)
        begin
          state_nxt = ST_DATA;
          bit_cnt_nxt = 4'h0;
          shift_nxt = 9'h000;
        end
      ST_DATA:
        if (bit_valid_i)
        begin
          shift_nxt[bit_cnt_r] = bit_value_i;
          bit_cnt_nxt = bit_cnt_r + 4'h1;
          if (bit_cnt_r == last_bit)
          begin
            state_nxt = par_en_r ? ST_PARITY : ST_STOP;
          end
        end
      ST_PARITY:
        if (bit_valid_i)
        begin
          par_bit_nxt = bit_value_i;
          state_nxt = ST_STOP;
        end
      ST_STOP:
        if (bit_valid_i)
        begin
          state_nxt = ST_IDLE;
          wait_nxt.data = shift_r;
          wait_nxt.stop_fault = ~bit_value_i;
          wait_nxt.overrun = lost_r;
          wait_nxt.parity_err = par_en_r & par_mismatch;
          wait_vld_nxt = 1'b1;
        end
      default:
        state_nxt = ST_IDLE;
    endcase
    if (flush)
    begin
      state_nxt = ST_IDLE;
      wait_vld_nxt = 1'b0;
      lost_nxt = 1'b0;
    end
  end

  // buffer pointers
  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r ^ move;
    rd_ptr_nxt = rd_ptr_r ^ pop;
    count_nxt = count_r + {1'b0, move} - {1'b0, pop};
    if (flush)
    begin
      wr_ptr_nxt = 1'b0;
      rd_ptr_nxt = 1'b0;
      count_nxt = 2'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      size_r <= SIZE_RESET;
      par_en_r <= 1'b0;
      par_odd_r <= 1'b0;
      two_stop_r <= 1'b0;
    end
    else
    begin
      irq_en_r <= irq_en_nxt;
      rx_en_r <= rx_en_nxt;
      size_r <= size_nxt;
      par_en_r <= par_en_nxt;
      par_odd_r <= par_odd_nxt;
      two_stop_r <= two_stop_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 9'h000;
      par_bit_r <= 1'b0;
      wait_r <= '0;
      wait_vld_r <= 1'b0;
      lost_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      par_bit_r <= par_bit_nxt;
      wait_r <= wait_nxt;
      wait_vld_r <= wait_vld_nxt;
      lost_r <= lost_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else
    begin
      if (move)
        buf_r[wr_ptr_r] <= wait_r;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prdata_r <= RDATA_RESET;
      err_r <= 1'b0;
      pop_ok_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      err_r <= err_nxt;
      pop_ok_r <= pop_ok_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = err_r & access;
  assign rx_irq_o = global_irq_en_i & irq_en_r & rx_complete;
  assign rx_pin_owned_o = rx_en_r;

endmodule // uart_receive_buffer_status

// *** verification/uart_rx_chk.sv ***
// port checker for the receive buffer block
`timescale 1ns/1ps

module uart_rx_chk
  import uart_rx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic bit_valid_i,
  input wire logic global_irq_en_i,
  input wire logic rx_irq_o,
  input wire logic rx_pin_owned_o
);
  logic wr_b;
  logic rd_d;
  logic ie_r;
  assign wr_b = psel_i & penable_i & pwrite_i & (paddr_i == ADDR_CTRL_B);
  assign rd_d = psel_i & penable_i & !pwrite_i & (paddr_i == ADDR_DATA);
  // shadow of the irq enable, kept from bus writes
  always_ff @(posedge clk_i)
    if (!rst_n_i)
      ie_r <= 1'b0;
    else if (wr_b)
      ie_r <= pwdata_i[CTLB_IRQ_EN];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_irq_global: assert property (rx_irq_o |-> global_irq_en_i)
    else $error("irq without global enable");
  a_irq_enable: assert property (rx_irq_o |-> ie_r)
    else $error("irq without enable");
  a_irq_hold: assert property (rx_irq_o && !rd_d && !wr_b
    |=> rx_irq_o || !global_irq_en_i) else $error("irq dropped");
  a_irq_cause: assert property ($rose(rx_irq_o) && $past(ie_r)
    && $past(global_irq_en_i) |-> $past(bit_valid_i, 2))
    else $error("irq rose without frame");
  a_pin_follow: assert property (wr_b
    |=> rx_pin_owned_o == $past(pwdata_i[CTLB_RX_EN]))
    else $error("pin not per enable");
  a_flush_now: assert property (wr_b && !pwdata_i[CTLB_RX_EN]
    |=> !rx_irq_o) else $error("no flush on disable");
  a_off_quiet: assert property (!rx_pin_owned_o |-> !rx_irq_o)
    else $error("request while off");
  a_upper_zero: assert property (rd_d
    |-> prdata_o[31:8] == 24'h00_0000) else $error("upper data bits set");
endmodule // uart_rx_chk

bind uart_receive_buffer_status uart_rx_chk u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .bit_valid_i(bit_valid_i),
  .global_irq_en_i(global_irq_en_i), .rx_irq_o(rx_irq_o),
  .rx_pin_owned_o(rx_pin_owned_o));

// *** verification/serial_tx_model.sv ***
// far-end transmitter model driving the recovered bit stream
`timescale 1ns/1ps

module serial_tx_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic send_i,
  input wire logic slow_i,
  input wire logic [8:0] char_i,
  input wire logic [3:0] nbits_i,
  input wire logic par_en_i,
  input wire logic par_i,
  input wire logic stop_i,
  output logic start_o,
  output logic valid_o,
  output logic value_o,
  output logic busy_o
);
  logic [11:0] seq;
  logic [11:0] sh_r;
  logic [3:0] left_r;
  logic step;
  // data lsb first, parity if on, then one stop bit
  assign seq = (12'(char_i) & ((12'h001 << nbits_i) - 12'h001))
    | (12'(par_i & par_en_i) << nbits_i)
    | (12'(stop_i) << (nbits_i + 4'(par_en_i)));
  // slow mode leaves an idle cycle after each bit
  assign step = (left_r != 4'h0) && !(slow_i && valid_o);
  assign busy_o = start_o | valid_o | (left_r != 4'h0);
  always_ff @(posedge clk_i)
    if (!rst_n_i)
    begin
      start_o <= 1'b0;
      valid_o <= 1'b0;
      value_o <= 1'b1;
      left_r <= 4'h0;
    end
    else
    begin
      start_o <= send_i;
      valid_o <= step;
      // no stale level between pulses
      value_o <= step ? sh_r[0] : !value_o;
      sh_r <= send_i ? seq : (step ? sh_r >> 1 : sh_r);
      left_r <= send_i ? nbits_i + 4'(par_en_i) + 4'h1 : left_r - 4'(step);
    end
endmodule // serial_tx_model

// *** verification/test_uart_receive_buffer_status.sv ***
// self-checking bench for the receive buffer block
`timescale 1ns/1ps

module test_uart_receive_buffer_status
  import uart_rx_pkg::*;
;
  logic clk_i, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gie = 1'b0, snd = 1'b0, slow = 1'b0, pen = 1'b0, pb = 1'b0;
  logic stp = 1'b1, start, bvalid, bval, busy, pready, pslverr, irq, pin;
  logic serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
  logic [8:0] chr = 9'h000;
  logic [3:0] nb = 4'h8;
  int err_count = 0, n_checks = 0, k;

  uart_receive_buffer_status u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .start_det_i(start), .bit_valid_i(bvalid),
    .bit_value_i(bval), .global_irq_en_i(gie), .rx_irq_o(irq),
    .rx_pin_owned_o(pin));
  serial_tx_model u_tx (.clk_i(clk_i), .rst_n_i(rst_n_i), .send_i(snd),
    .slow_i(slow), .char_i(chr), .nbits_i(nb), .par_en_i(pen), .par_i(pb),
    .stop_i(stp), .start_o(start), .valid_o(bvalid), .value_o(bval),
    .busy_o(busy));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task hang;
    err_count++;
    give_verdict;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    for (i = 0; i < 9 && pready !== 1'b1; i++)
      @(posedge clk_i);
    if (pready !== 1'b1)
      hang;
    rdv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), rdv, e);
  endtask
  task get(input logic [7:0] st, input logic [7:0] c);
    rd(ADDR_STATUS, 32'(st));
    rd(ADDR_DATA, 32'(c));
  endtask
  task flags(input logic i, input logic p);
    chk("irq", 32'(irq), 32'(i));
    chk("pin", 32'(pin), 32'(p));
  endtask
  task send(input logic [8:0] c, input logic p, input logic s);
    int i;
    chr <= c;
    pb <= p;
    stp <= s;
    snd <= 1'b1;
    @(posedge clk_i);
    snd <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 60 && busy !== 1'b0; i++)
      @(posedge clk_i);
    if (busy !== 1'b0)
      hang;
    repeat (3) @(posedge clk_i);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(ADDR_CTRL_B, 32'h0000_0000);
    rd(ADDR_CTRL_C, 32'h0000_0006);
    rd(ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'h0000_00FF);
    chk("slverr", 32'(serr), 32'h0000_0001);
    flags(1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL_B, 32'h0000_0090);
    gie <= 1'b1;
    send(9'h0A5, 1'b0, 1'b1);
    flags(1'b1, 1'b1);
    get(8'h80, 8'hA5);
    flags(1'b0, 1'b1);
    send(9'h03C, 1'b0, 1'b0);
    apb(1'b1, ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL_C, 32'h0000_000E);
    send(9'h0C3, 1'b0, 1'b0);
    get(8'h90, 8'h3C);
    get(8'h90, 8'hC3);
    pen <= 1'b1;
    // 0xB7 has even weight, so the right parity bit equals k
    for (k = 0; k < 2; k++)
    begin
      apb(1'b1, ADDR_CTRL_C, 32'h0000_0026 | 32'(k << 4));
      send(9'h0B7, k[0], 1'b1);
      send(9'h0B7, !k[0], 1'b1);
      get(8'h80, 8'hB7);
      get(8'h84, 8'hB7);
    end
    apb(1'b1, ADDR_CTRL_C, 32'h0000_0016);
    pen <= 1'b0;
    send(9'h0B6, 1'b0, 1'b1);
    apb(1'b1, ADDR_CTRL_C, 32'h0000_0000);
    get(8'h80, 8'hB6);
    nb <= 4'h5;
    send(9'h0FF, 1'b0, 1'b1);
    get(8'h80, 8'h1F);
    apb(1'b1, ADDR_CTRL_B, 32'h0000_0094);
    apb(1'b1, ADDR_CTRL_C, 32'h0000_0006);
    nb <= 4'h9;
    send(9'h1A5, 1'b0, 1'b1);
    rd(ADDR_STATUS, 32'h0000_0080);
    rd(ADDR_CTRL_B, 32'h0000_0096);
    rd(ADDR_DATA, 32'h0000_00A5);
    apb(1'b1, ADDR_CTRL_B, 32'h0000_0090);
    nb <= 4'h8;
    for (k = 1; k < 5; k++)
    begin
      slow <= (k == 4);
      send(9'(k), 1'b0, 1'b1);
    end
    slow <= 1'b0;
    get(8'h80, 8'h01);
    get(8'h80, 8'h02);
    get(8'h88, 8'h04);
    send(9'h005, 1'b0, 1'b1);
    get(8'h80, 8'h05);
    send(9'h006, 1'b0, 1'b1);
    // irq enable kept on, so only the flush can drop the request
    apb(1'b1, ADDR_CTRL_B, 32'h0000_0080);
    flags(1'b0, 1'b0);
    send(9'h007, 1'b0, 1'b1);
    apb(1'b1, ADDR_CTRL_B, 32'h0000_0090);
    rd(ADDR_STATUS, 32'h0000_0000);
    // disable in mid-frame; the rest of the frame must not land
    slow <= 1'b1;
    chr <= 9'h055;
    snd <= 1'b1;
    @(posedge clk_i);
    snd <= 1'b0;
    repeat (3) @(posedge clk_i);
    apb(1'b1, ADDR_CTRL_B, 32'h0000_0080);
    apb(1'b1, ADDR_CTRL_B, 32'h0000_0090);
    for (k = 0; k < 60 && busy !== 1'b0; k++)
      @(posedge clk_i);
    if (busy !== 1'b0)
      hang;
    slow <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(ADDR_STATUS, 32'h0000_0000);
    send(9'h008, 1'b0, 1'b1);
    send(9'h009, 1'b0, 1'b1);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      if (rdv[STAT_RX_COMPLETE] !== 1'b1)
        break;
      apb(1'b0, ADDR_DATA, 32'h0000_0000);
    end
    chk("flushed", 32'(k), 32'h0000_0002);
    give_verdict;
  end
endmodule // test_uart_receive_buffer_status
